// >>> perf_event_select.sv
// performance counter event selection for the memory-controller unit, APB slave
//
// Functional notes
// [R1] flag clear: control bits 13:9 pick a direct event, at most one per clock
// [R2] flag bit 7 set: bits 21:19 pick a duration event, one per clock in state
// [R3] code 0x1a counts each upstream command accepted by the unit
// [R4] code 0x01 counts clocks in the badly-starved full condition
// [R5] dispatch duration counts clocks in states chosen by 4-bit dispatch field
// [R6] duration 5 counts clocks in closed (0) or open (1) page policy
// [R7] duration 4 counts clocks the retry queue is starved
// [R8] duration 3 counts clocks the retry queue is badly-starved full
// [R9] duration 1 counts clocks in scheduling mode from issue field bits 6:4
// [R10] duration 6 tracks occupancy of the upstream command scheduler queue; the code counts one per clock while schedq_busy is set
// [R11] code 0x0a with qualifier bits 13 and 0 clear counts every issued memory command
// [R12] command-type field 12:8 selects which memory command kind is counted
// [R13] qualifier bit 0 set restricts commands to issue-field mode bits 9:7
// [R14] software clears filter bits 13, 7 and 0 for an unfiltered command count
// [R15] codes 0x04 and 0x05 count thermal trip crossings up and down, qualified
// [R16] codes 0x13, 0x14, 0x15 count page misses, hits and auto page closes
// [R17] code 0x19 counts thermal throttling versus command issue conflicts
// [R18] a counter advances only while enabled and its selected condition is true
module perf_event_select (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // scheduler and command source events
  input wire logic upcmd_accept,
  input wire logic unit_mfull,
  input wire logic retry_queue_mfull,
  input wire logic retry_queue_starved,
  input wire logic rdq_full,
  input wire logic wrq_full,
  input wire logic rdq_empty,
  input wire logic wrq_empty,
  input wire logic [2:0] sched_mode,
  input wire logic page_open,
  input wire logic schedq_busy,
  // memory command issue
  input wire logic mem_cmd_valid,
  input wire logic [4:0] mem_cmd_type,
  // page table and thermal events
  input wire logic page_miss,
  input wire logic page_hit,
  input wire logic page_autoclose,
  input wire logic tt_conflict,
  input wire logic [7:0] therm_up_trip,
  input wire logic [7:0] therm_dn_trip,
  // counter values for observation
  output logic [31:0] count0,
  output logic [31:0] count1
);

  // ============================================================
  // helpers
  // pick the trip crossing of one dimm or of all dimms
  function automatic logic dimm_event(input logic [7:0] trips, input logic all, input logic [2:0] sel);
    dimm_event = all ? (|trips) : trips[sel];
  endfunction

  // dispatch field is a set of conditions; any selected one being true counts
  function automatic logic dsp_event(input logic [3:0] field, input logic [3:0] cond);
    dsp_event = |(field & cond);
  endfunction

  // ============================================================
  // bus decode
  logic [31:0] ctrl [perf_sel_pkg::NUM_CNT];
  logic [31:0] count [perf_sel_pkg::NUM_CNT];
  logic [31:0] dsp_sub;
  logic [31:0] issue_subfield;
  logic [31:0] page_table_subfield;
  logic [31:0] thermal_subfield;
  logic [31:0] pld_sub;
  logic [perf_sel_pkg::NUM_CNT-1:0] ctrl_hit;
  logic [perf_sel_pkg::NUM_CNT-1:0] cnt_hit;
  logic [perf_sel_pkg::NUM_CNT-1:0] cnt_wr;
  logic [perf_sel_pkg::NUM_CNT-1:0] cnt_inc;
  logic wr_en;
  logic setup_rd;
  logic dsp_hit;
  logic issue_cfg_hit;
  logic page_cfg_hit;
  logic therm_cfg_hit;
  logic pld_hit;
  logic addr_ok;
  logic [31:0] rd_mux;

  assign wr_en = psel && penable && pwrite;
  assign setup_rd = psel && !penable && !pwrite;
  assign dsp_hit = (paddr == perf_sel_pkg::OFS_DSP);
  assign issue_cfg_hit = (paddr == perf_sel_pkg::OFS_ISSUE);
  assign page_cfg_hit = (paddr == perf_sel_pkg::OFS_PAGE);
  assign therm_cfg_hit = (paddr == perf_sel_pkg::OFS_THERM);
  assign pld_hit = (paddr == perf_sel_pkg::OFS_PLD);
  assign addr_ok = (|ctrl_hit) || (|cnt_hit) || dsp_hit || issue_cfg_hit || page_cfg_hit
    || therm_cfg_hit || pld_hit;

  // zero wait states; unmapped addresses answer with an error and read zero
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (dsp_hit) begin
      rd_mux = dsp_sub;
    end else if (issue_cfg_hit) begin
      rd_mux = issue_subfield;
    end else if (page_cfg_hit) begin
      rd_mux = page_table_subfield;
    end else if (therm_cfg_hit) begin
      rd_mux = thermal_subfield;
    end else if (pld_hit) begin
      rd_mux = pld_sub;
    end else begin
      for (int i = 0; i < perf_sel_pkg::NUM_CNT; i++) begin
        if (ctrl_hit[i]) begin
          rd_mux = ctrl[i];
        end
        if (cnt_hit[i]) begin
          rd_mux = count[i];
        end
      end
    end
  end

  // read data is captured in the setup cycle so prdata comes from a flop
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prdata <= 32'h0000_0000;
    end else if (setup_rd) begin
      prdata <= rd_mux;
    end
  end

  // ============================================================
  // subunit control registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dsp_sub <= perf_sel_pkg::SUB_RST;
      issue_subfield <= perf_sel_pkg::SUB_RST;
      page_table_subfield <= perf_sel_pkg::SUB_RST;
      thermal_subfield <= perf_sel_pkg::SUB_RST;
      pld_sub <= perf_sel_pkg::SUB_RST;
    end else if (wr_en) begin
      if (dsp_hit) dsp_sub <= pwdata & perf_sel_pkg::DSP_MASK;
      if (issue_cfg_hit) issue_subfield <= pwdata & perf_sel_pkg::ISSUE_MASK;
      if (page_cfg_hit) page_table_subfield <= pwdata & perf_sel_pkg::PAGE_MASK;
      if (therm_cfg_hit) thermal_subfield <= pwdata & perf_sel_pkg::THERM_MASK;
      if (pld_hit) pld_sub <= pwdata & perf_sel_pkg::PLD_MASK;
    end
  end

  // ============================================================
  // subfield decode
  logic [3:0] dsp_field;
  logic [3:0] dsp_cond;
  logic [2:0] dur_mode;
  logic [2:0] cmd_mode;
  logic [4:0] cmd_type_sel;
  logic type_filter;
  logic mode_filter;
  logic mem_cmd_hit;
  logic dsp_now;

  assign dsp_field = dsp_sub[perf_sel_pkg::DSP_LO +: 4];
  assign dsp_cond = {wrq_empty, rdq_empty, wrq_full, rdq_full}; // [R5]
  assign dsp_now = dsp_event(dsp_field, dsp_cond); // [R5]
  assign dur_mode = issue_subfield[perf_sel_pkg::ISSUE_MODE_LO +: 3];
  assign cmd_mode = issue_subfield[perf_sel_pkg::ISSUE_CMDMODE_LO +: 3];
  assign cmd_type_sel = pld_sub[perf_sel_pkg::PLD_TYPE_LO +: 5];
  assign type_filter = pld_sub[perf_sel_pkg::PLD_TYPE_EN];
  assign mode_filter = pld_sub[perf_sel_pkg::PLD_MODE_EN];

  // with both filters clear every issued command counts, whatever its type
  assign mem_cmd_hit = mem_cmd_valid // [R11]
    && (!type_filter || (mem_cmd_type == cmd_type_sel)) // [R12]
    && (!mode_filter || (sched_mode == cmd_mode)); // [R13]

  // ============================================================
  // event vectors indexed by the selection codes
  logic [31:0] direct_vec;
  logic [7:0] dur_vec;

  always_comb begin
    direct_vec = 32'h0000_0000;
    direct_vec[perf_sel_pkg::EV_DSP_FILL] = dsp_now;
    direct_vec[perf_sel_pkg::EV_MFULL] = unit_mfull; // [R4]
    direct_vec[perf_sel_pkg::EV_RETRY_MFULL] = retry_queue_mfull;
    direct_vec[perf_sel_pkg::EV_RETRY_STARVE] = retry_queue_starved;
    direct_vec[perf_sel_pkg::EV_TRP_UP] = dimm_event(therm_up_trip, thermal_subfield[perf_sel_pkg::THERM_ALL],
      thermal_subfield[perf_sel_pkg::THERM_DIMM_LO +: 3]); // [R15]
    direct_vec[perf_sel_pkg::EV_TRP_DN] = dimm_event(therm_dn_trip, thermal_subfield[perf_sel_pkg::THERM_ALL],
      thermal_subfield[perf_sel_pkg::THERM_DIMM_LO +: 3]); // [R15]
    direct_vec[perf_sel_pkg::EV_DRAM_CMD] = mem_cmd_hit; // [R11]
    direct_vec[perf_sel_pkg::EV_PAGE_MISS] = page_miss; // [R16]
    direct_vec[perf_sel_pkg::EV_PAGE_HIT] = page_hit; // [R16]
    direct_vec[perf_sel_pkg::EV_PAGE_CLOSE] = page_autoclose; // [R16]
    direct_vec[perf_sel_pkg::EV_TT_CONFLICT] = tt_conflict; // [R17]
    direct_vec[perf_sel_pkg::EV_UPCMD] = upcmd_accept; // [R3]
    direct_vec[perf_sel_pkg::EV_CYCLES] = 1'b1;
  end

  // occupancy is one bit per clock here; a multi-entry sum would break the one-per-clock limit
  always_comb begin
    dur_vec = 8'h00;
    dur_vec[perf_sel_pkg::DUR_DSP] = dsp_now; // [R5]
    dur_vec[perf_sel_pkg::DUR_SCHED] = (sched_mode == dur_mode); // [R9]
    dur_vec[perf_sel_pkg::DUR_RQ_MFULL] = retry_queue_mfull; // [R8]
    dur_vec[perf_sel_pkg::DUR_RQ_STARVE] = retry_queue_starved; // [R7]
    dur_vec[perf_sel_pkg::DUR_PAGE] = (page_open == page_table_subfield[perf_sel_pkg::PAGE_OPEN_BIT]); // [R6]
    dur_vec[perf_sel_pkg::DUR_SCHEDQ] = schedq_busy; // [R10]
  end

  // ============================================================
  // counters and their control words
  for (genvar i = 0; i < perf_sel_pkg::NUM_CNT; i++) begin : g_cnt
    logic [4:0] inc_code;
    logic [2:0] set_code;

    assign ctrl_hit[i] = (paddr == 8'(perf_sel_pkg::OFS_CTRL0 + 8'(i) * perf_sel_pkg::CNT_STRIDE));
    assign cnt_hit[i] = (paddr == 8'(perf_sel_pkg::OFS_CNT0 + 8'(i) * perf_sel_pkg::CNT_STRIDE));
    assign cnt_wr[i] = wr_en && cnt_hit[i];
    assign inc_code = ctrl[i][perf_sel_pkg::CTL_INC_LO +: 5];
    assign set_code = ctrl[i][perf_sel_pkg::CTL_SET_LO +: 3];
    assign cnt_inc[i] = ctrl[i][perf_sel_pkg::CTL_FLAG] ? dur_vec[set_code] : direct_vec[inc_code]; // [R1] [R2]

    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        ctrl[i] <= perf_sel_pkg::CTRL_RST;
      end else if (wr_en && ctrl_hit[i]) begin
        ctrl[i] <= pwdata & perf_sel_pkg::CTRL_MASK;
      end
    end

    event_counter u_cnt (
      .clk(clk),
      .nrst(nrst),
      .enable(ctrl[i][perf_sel_pkg::CTL_EN]),
      .inc(cnt_inc[i]),
      .load(cnt_wr[i]),
      .load_value(pwdata),
      .count(count[i])
    );
  end

  assign count0 = count[0];
  assign count1 = count[1];

  // ============================================================
  // checks on counter 0
  logic c0_en;
  logic c0_flag;
  logic [4:0] c0_code;
  logic [2:0] c0_set;
  logic c0_free;

  assign c0_en = ctrl[0][perf_sel_pkg::CTL_EN];
  assign c0_flag = ctrl[0][perf_sel_pkg::CTL_FLAG];
  assign c0_code = ctrl[0][perf_sel_pkg::CTL_INC_LO +: 5];
  assign c0_set = ctrl[0][perf_sel_pkg::CTL_SET_LO +: 3];
  assign c0_free = c0_en && !cnt_wr[0];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_bumped;
    count0 == $past(count0) + 32'h0000_0001;
  endsequence

  sequence s_held;
    count0 == $past(count0);
  endsequence

  property p_bump(cond);
    cond |=> s_bumped;
  endproperty

  property p_hold(cond);
    cond |=> s_held;
  endproperty

  a_upcmd_count: assert property (p_bump(c0_free && !c0_flag && c0_code == perf_sel_pkg::EV_UPCMD && upcmd_accept)) // [R3]
    else $error("accepted upstream command not counted");
  a_direct_idle: assert property (p_hold(c0_free && !c0_flag && c0_code == perf_sel_pkg::EV_UPCMD && !upcmd_accept)) // [R1]
    else $error("direct counter moved without its event");
  a_mfull_cycles: assert property (p_bump(c0_free && !c0_flag && c0_code == perf_sel_pkg::EV_MFULL && unit_mfull)) // [R4]
    else $error("full cycle not counted");
  a_flag_overrides: assert property (p_hold(c0_free && c0_flag && c0_code == perf_sel_pkg::EV_CYCLES // [R2]
    && c0_set == perf_sel_pkg::DUR_RQ_STARVE && !retry_queue_starved))
    else $error("direct code counted while flag set");
  a_retry_starved: assert property (p_bump(c0_free && c0_flag && c0_set == perf_sel_pkg::DUR_RQ_STARVE // [R7]
    && retry_queue_starved))
    else $error("starved clock not counted");
  a_retry_mfull: assert property (p_bump(c0_free && c0_flag && c0_set == perf_sel_pkg::DUR_RQ_MFULL // [R8]
    && retry_queue_mfull))
    else $error("retry full clock not counted");
  a_page_policy: assert property (p_hold(c0_free && c0_flag && c0_set == perf_sel_pkg::DUR_PAGE // [R6]
    && page_open != page_table_subfield[perf_sel_pkg::PAGE_OPEN_BIT]))
    else $error("wrong page policy counted");
  a_sched_mode: assert property (p_bump(c0_free && c0_flag && c0_set == perf_sel_pkg::DUR_SCHED // [R9]
    && sched_mode == dur_mode))
    else $error("scheduling mode clock not counted");
  a_dsp_state: assert property (p_bump(c0_free && c0_flag && c0_set == perf_sel_pkg::DUR_DSP // [R5]
    && dsp_field[3] && wrq_empty))
    else $error("write queue empty clock not counted");
  a_cmd_unfiltered: assert property (p_bump(c0_free && !c0_flag && c0_code == perf_sel_pkg::EV_DRAM_CMD // [R11]
    && !type_filter && !mode_filter && mem_cmd_valid))
    else $error("memory command not counted");
  a_cmd_type: assert property (p_hold(c0_free && !c0_flag && c0_code == perf_sel_pkg::EV_DRAM_CMD // [R12]
    && type_filter && mem_cmd_type != cmd_type_sel))
    else $error("filtered command type counted");
  a_cmd_mode: assert property (p_hold(c0_free && !c0_flag && c0_code == perf_sel_pkg::EV_DRAM_CMD // [R13]
    && mode_filter && sched_mode != cmd_mode))
    else $error("command counted in wrong mode");
  a_disabled_hold: assert property ((!c0_en && !cnt_wr[0]) [*2] |=> $stable(count0)) // [R18]
    else $error("disabled counter moved");
  a_schedq_busy: assert property (p_bump(c0_free && c0_flag && c0_set == perf_sel_pkg::DUR_SCHEDQ // [R10]
    && schedq_busy))
    else $error("busy scheduler queue clock not counted");
  a_therm_up: assert property (p_bump(c0_free && !c0_flag && c0_code == perf_sel_pkg::EV_TRP_UP // [R15]
    && thermal_subfield[perf_sel_pkg::THERM_ALL] && (|therm_up_trip)))
    else $error("upward trip crossing not counted");
  a_therm_dn: assert property (p_hold(c0_free && !c0_flag && c0_code == perf_sel_pkg::EV_TRP_DN // [R15]
    && thermal_subfield[perf_sel_pkg::THERM_ALL] && !(|therm_dn_trip)))
    else $error("downward trip counted without a crossing");
  a_page_miss: assert property (p_bump(c0_free && !c0_flag && c0_code == perf_sel_pkg::EV_PAGE_MISS // [R16]
    && page_miss))
    else $error("page miss not counted");
  a_page_close: assert property (p_bump(c0_free && !c0_flag && c0_code == perf_sel_pkg::EV_PAGE_CLOSE // [R16]
    && page_autoclose))
    else $error("auto page close not counted");
  a_tt_conflict: assert property (p_bump(c0_free && !c0_flag && c0_code == perf_sel_pkg::EV_TT_CONFLICT // [R17]
    && tt_conflict))
    else $error("throttle conflict not counted");
  a_cmd_typed: assert property (p_bump(c0_free && !c0_flag && c0_code == perf_sel_pkg::EV_DRAM_CMD // [R12]
    && type_filter && !mode_filter && mem_cmd_valid && mem_cmd_type == cmd_type_sel))
    else $error("selected command type not counted");
  a_load_wins: assert property (cnt_wr[0] |=> count0 == $past(pwdata)) // [R18]
    else $error("count write not loaded exactly");

endmodule

// >>> perf_sel_pkg.sv
// constants shared by the memory-controller event selection logic
package perf_sel_pkg;

  // ============================================================
  // sizes
  localparam int NUM_CNT = 2;
  localparam int NUM_DIMM = 8;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;

  // ============================================================
  // register offsets
  localparam logic [7:0] OFS_CTRL0 = 8'h00;
  localparam logic [7:0] OFS_CNT0 = 8'h04;
  localparam logic [7:0] CNT_STRIDE = 8'h08;
  localparam logic [7:0] OFS_DSP = 8'h20;
  localparam logic [7:0] OFS_ISSUE = 8'h24;
  localparam logic [7:0] OFS_PAGE = 8'h28;
  localparam logic [7:0] OFS_THERM = 8'h2C;
  localparam logic [7:0] OFS_PLD = 8'h30;

  // ============================================================
  // reset values and writable-bit masks
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] SUB_RST = 32'h0000_0000;
  localparam logic [31:0] CNT_RST = 32'h0000_0000;
  localparam logic [31:0] CTRL_MASK = 32'h0038_3E81;
  localparam logic [31:0] DSP_MASK = 32'h0000_0780;
  localparam logic [31:0] ISSUE_MASK = 32'h0000_03F0;
  localparam logic [31:0] PAGE_MASK = 32'h0000_0040;
  localparam logic [31:0] THERM_MASK = 32'h0000_0078;
  localparam logic [31:0] PLD_MASK = 32'h0000_3F01;

  // ============================================================
  // field positions
  localparam int CTL_EN = 0;
  localparam int CTL_FLAG = 7;
  localparam int CTL_INC_LO = 9;
  localparam int CTL_SET_LO = 19;
  localparam int DSP_LO = 7;
  localparam int ISSUE_MODE_LO = 4;
  localparam int ISSUE_CMDMODE_LO = 7;
  localparam int PAGE_OPEN_BIT = 6;
  localparam int THERM_ALL = 3;
  localparam int THERM_DIMM_LO = 4;
  localparam int PLD_MODE_EN = 0;
  localparam int PLD_TYPE_LO = 8;
  localparam int PLD_TYPE_EN = 13;

  // ============================================================
  // per-cycle event codes
  localparam logic [4:0] EV_DSP_FILL = 5'h00;
  localparam logic [4:0] EV_MFULL = 5'h01;
  localparam logic [4:0] EV_RETRY_MFULL = 5'h02;
  localparam logic [4:0] EV_RETRY_STARVE = 5'h03;
  localparam logic [4:0] EV_TRP_UP = 5'h04;
  localparam logic [4:0] EV_TRP_DN = 5'h05;
  localparam logic [4:0] EV_DRAM_CMD = 5'h0A;
  localparam logic [4:0] EV_PAGE_MISS = 5'h13;
  localparam logic [4:0] EV_PAGE_HIT = 5'h14;
  localparam logic [4:0] EV_PAGE_CLOSE = 5'h15;
  localparam logic [4:0] EV_TT_CONFLICT = 5'h19;
  localparam logic [4:0] EV_UPCMD = 5'h1A;
  localparam logic [4:0] EV_CYCLES = 5'h1B;

  // ============================================================
  // duration codes
  localparam logic [2:0] DUR_DSP = 3'h0;
  localparam logic [2:0] DUR_SCHED = 3'h1;
  localparam logic [2:0] DUR_RQ_MFULL = 3'h3;
  localparam logic [2:0] DUR_RQ_STARVE = 3'h4;
  localparam logic [2:0] DUR_PAGE = 3'h5;
  localparam logic [2:0] DUR_SCHEDQ = 3'h6;

  // ============================================================
  // scheduling modes and command types
  localparam logic [2:0] MODE_TRADEOFF = 3'h0;
  localparam logic [2:0] MODE_RDPRIO = 3'h1;
  localparam logic [2:0] MODE_WRPRIO = 3'h2;
  localparam logic [2:0] MODE_ADAPTIVE = 3'h3;
  localparam logic [4:0] CMD_ILLEGAL = 5'h00;
  localparam logic [4:0] CMD_PREALL = 5'h01;
  localparam logic [4:0] CMD_RAS = 5'h02;
  localparam logic [4:0] CMD_CAS_RD_OPN = 5'h03;
  localparam logic [4:0] CMD_CAS_WR_OPN = 5'h04;
  localparam logic [4:0] CMD_CAS_RD_CLS = 5'h05;
  localparam logic [4:0] CMD_CAS_WR_CLS = 5'h06;

endpackage

// >>> event_counter.sv
// one 32-bit event counter with software load
module event_counter (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // control
  input wire logic enable,
  input wire logic inc,
  input wire logic load,
  input wire logic [31:0] load_value,
  // state
  output logic [31:0] count
);

  // ============================================================
  // counting
  // a software load wins over a coincident increment so the loaded value is exact
  logic [31:0] next_count;

  assign next_count = load ? load_value : ((enable && inc) ? count + 32'h0000_0001 : count); // [R18]

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count <= perf_sel_pkg::CNT_RST;
    end else begin
      count <= next_count;
    end
  end

endmodule

// >>> tb.sv
// self-checking testbench for the memory-controller event selection block
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ============================================================
  // signals
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr;
  logic upcmd_accept = 1'b0, unit_mfull = 1'b0, retry_queue_mfull = 1'b0, retry_queue_starved = 1'b0;
  logic rdq_full = 1'b0, wrq_full = 1'b0, rdq_empty = 1'b0, wrq_empty = 1'b0;
  logic [2:0] sched_mode = 3'h0;
  logic page_open = 1'b0, schedq_busy = 1'b0, mem_cmd_valid = 1'b0;
  logic [4:0] mem_cmd_type = 5'h00;
  logic page_miss = 1'b0, page_hit = 1'b0, page_autoclose = 1'b0, tt_conflict = 1'b0;
  logic [7:0] therm_up_trip = 8'h00, therm_dn_trip = 8'h00;
  logic [31:0] count0, count1;
  int n_errors = 0, cmp_count = 0, cyc = 0;
  logic [31:0] m_ctrl [2];
  logic [31:0] exp_cnt [2];
  logic [31:0] m_dsp, m_issue, m_page, m_therm, m_pld;
  wire wen = psel & penable & pwrite & pready;

  perf_event_select dut_u (
    .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .upcmd_accept(upcmd_accept), .unit_mfull(unit_mfull), .retry_queue_mfull(retry_queue_mfull),
    .retry_queue_starved(retry_queue_starved), .rdq_full(rdq_full), .wrq_full(wrq_full),
    .rdq_empty(rdq_empty),
    .wrq_empty(wrq_empty), .sched_mode(sched_mode), .page_open(page_open), .schedq_busy(schedq_busy),
    .mem_cmd_valid(mem_cmd_valid), .mem_cmd_type(mem_cmd_type), .page_miss(page_miss),
    .page_hit(page_hit), .page_autoclose(page_autoclose), .tt_conflict(tt_conflict),
    .therm_up_trip(therm_up_trip), .therm_dn_trip(therm_dn_trip), .count0(count0), .count1(count1)
  );

  always #25 clk = ~clk;

  // ============================================================
  // reference model
  function automatic logic hit(input logic [31:0] c);
    logic dsp, tup, tdn, cmd;
    dsp = |(m_dsp[10:7] & {wrq_empty, rdq_empty, wrq_full, rdq_full});
    tup = m_therm[3] ? |therm_up_trip : therm_up_trip[m_therm[6:4]];
    tdn = m_therm[3] ? |therm_dn_trip : therm_dn_trip[m_therm[6:4]];
    cmd = mem_cmd_valid && (!m_pld[13] || mem_cmd_type === m_pld[12:8])
          && (!m_pld[0] || sched_mode === m_issue[9:7]);
    if (c[0] !== 1'b1) return 1'b0;
    if (c[7]) begin
      case (c[21:19])
        3'h0: return dsp;
        3'h1: return sched_mode === m_issue[6:4];
        3'h3: return retry_queue_mfull;
        3'h4: return retry_queue_starved;
        3'h5: return page_open === m_page[6];
        3'h6: return schedq_busy;
        default: return 1'b0;
      endcase
    end
    case (c[13:9])
      5'h00: return dsp;
      5'h01: return unit_mfull;
      5'h02: return retry_queue_mfull;
      5'h03: return retry_queue_starved;
      5'h04: return tup;
      5'h05: return tdn;
      5'h0A: return cmd;
      5'h13: return page_miss;
      5'h14: return page_hit;
      5'h15: return page_autoclose;
      5'h19: return tt_conflict;
      5'h1A: return upcmd_accept;
      5'h1B: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // increments use the control word held before this edge; a count write beats an increment
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      m_ctrl[0] <= 32'h0;
      m_ctrl[1] <= 32'h0;
      exp_cnt[0] <= 32'h0;
      exp_cnt[1] <= 32'h0;
      m_dsp <= 32'h0;
      m_issue <= 32'h0;
      m_page <= 32'h0;
      m_therm <= 32'h0;
      m_pld <= 32'h0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (wen && paddr == 8'(8'h04 + 8 * c)) exp_cnt[c] <= pwdata;
        else if (hit(m_ctrl[c])) exp_cnt[c] <= exp_cnt[c] + 32'h1;
      end
      if (wen) begin
        case (paddr)
          8'h00: m_ctrl[0] <= pwdata & perf_sel_pkg::CTRL_MASK;
          8'h08: m_ctrl[1] <= pwdata & perf_sel_pkg::CTRL_MASK;
          perf_sel_pkg::OFS_DSP: m_dsp <= pwdata & perf_sel_pkg::DSP_MASK;
          perf_sel_pkg::OFS_ISSUE: m_issue <= pwdata & perf_sel_pkg::ISSUE_MASK;
          perf_sel_pkg::OFS_PAGE: m_page <= pwdata & perf_sel_pkg::PAGE_MASK;
          perf_sel_pkg::OFS_THERM: m_therm <= pwdata & perf_sel_pkg::THERM_MASK;
          perf_sel_pkg::OFS_PLD: m_pld <= pwdata & perf_sel_pkg::PLD_MASK;
          default: ;
        endcase
      end
    end
  end

  function automatic logic [31:0] reg_exp(input logic [7:0] a);
    case (a)
      8'h00: return m_ctrl[0];
      8'h04: return exp_cnt[0];
      8'h08: return m_ctrl[1];
      8'h0C: return exp_cnt[1];
      perf_sel_pkg::OFS_DSP: return m_dsp;
      perf_sel_pkg::OFS_ISSUE: return m_issue;
      perf_sel_pkg::OFS_PAGE: return m_page;
      perf_sel_pkg::OFS_THERM: return m_therm;
      perf_sel_pkg::OFS_PLD: return m_pld;
      default: return 32'h0;
    endcase
  endfunction

  // ============================================================
  // checking and bus tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // waits an edge first so the previous release never meets a new setup in one step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 16) begin
      n++;
      @(posedge clk);
    end
    chk({31'h0, pready}, 32'h1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  // ============================================================
  // per-cycle comparison and timeout
  always @(negedge clk) begin
    if (nrst) begin
      chk(count0, exp_cnt[0]);
      chk(count1, exp_cnt[1]);
    end
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      test_done();
    end
  end

  // ============================================================
  // main sequence
  initial begin
    logic [31:0] q, sel, r;
    logic e;
    logic [7:0] addrs [10];
    addrs = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h20, 8'h24, 8'h28, 8'h2C, 8'h30, 8'h40};
    void'($urandom(32'h2b7dd92a));
    fork
      forever begin
        @(posedge clk);
        r = $urandom;
        {upcmd_accept, unit_mfull, retry_queue_mfull, retry_queue_starved} <= r[3:0];
        {rdq_full, wrq_full, rdq_empty, wrq_empty, page_open, schedq_busy} <= r[9:4];
        {mem_cmd_valid, page_miss, page_hit, page_autoclose, tt_conflict} <= r[14:10];
        sched_mode <= 3'($urandom_range(0, 3));
        mem_cmd_type <= 5'($urandom_range(0, 7));
        therm_up_trip <= 8'($urandom & $urandom);
        therm_dn_trip <= 8'($urandom & $urandom);
      end
    join_none
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    foreach (addrs[k]) begin
      apb(1'b0, addrs[k], 32'h0, q, e);
      chk(q, 32'h0);
    end
    // every direct code, then every duration code; odd passes leave the filters clear
    for (int i = 0; i < 40; i++) begin
      sel = (i < 32) ? {18'h0, i[4:0], 9'h0} : {10'h0, i[2:0], 11'h0, 1'b1, 7'h0};
      wr(perf_sel_pkg::OFS_DSP, $urandom);
      wr(perf_sel_pkg::OFS_ISSUE, $urandom);
      wr(perf_sel_pkg::OFS_PAGE, $urandom);
      wr(perf_sel_pkg::OFS_THERM, $urandom);
      wr(perf_sel_pkg::OFS_PLD, i[0] ? 32'h0 : $urandom);
      wr(8'h00, sel | 32'h1 | ($urandom & 32'hFF00_0000));
      wr(8'h08, sel | {31'h0, 1'($urandom)});
      wr(8'h04, (i == 27) ? 32'hFFFF_FFFE : $urandom);
      repeat (30) @(posedge clk);
      apb(1'b0, 8'h00, 32'h0, q, e);
      chk(q, reg_exp(8'h00));
    end
    wr(8'h00, 32'h0);
    wr(8'h08, 32'h0);
    apb(1'b1, 8'h40, $urandom, q, e);
    chk({31'h0, e}, 32'h1);
    foreach (addrs[k]) begin
      apb(1'b0, addrs[k], 32'h0, q, e);
      chk(q, reg_exp(addrs[k]));
      chk({31'h0, e}, {31'h0, addrs[k] == 8'h40});
    end
    test_done();
  end
endmodule
